// ===== core/hbsws_regs.vh
`ifndef HBSWS_REGS_VH
`define HBSWS_REGS_VH
// ----------------------------------------------------------------------
// Host mode encodings
// ----------------------------------------------------------------------
`define HBSWS_MODE_0 2'h0
`define HBSWS_MODE_1 2'h1
`define HBSWS_MODE_2 2'h2
`define HBSWS_MODE_3 2'h3
// ----------------------------------------------------------------------
// Bus states, one-hot
// ----------------------------------------------------------------------
`define HBSWS_ST_IDLE 5'h01
`define HBSWS_ST_T1 5'h02
`define HBSWS_ST_T2 5'h04
`define HBSWS_ST_TW 5'h08
`define HBSWS_ST_T3 5'h10
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HBSWS_CLK_PERIOD_NS 8
`define HBSWS_SLAVE_WAIT_CYCLES 4'h2
`endif

// ===== core/hbsws_wait_sampler.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Wait line sampler
// ----------------------------------------------------------------------
// The falling-edge sample is modelled as the level at this edge or the one
// before; with synchronous inputs a wait is seen one edge longer than on the rising edge.
module hbsws_wait_sampler (
    input wire clock_in,
    input wire rst_n_in,
    input wire wait_in,
    input wire falling_sel_in,
    output reg wait_high_out
);
    reg wait_prev;
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_prev <= 1'b0;
        end else begin
            wait_prev <= wait_in;
        end
    end
    always @* begin
        wait_high_out = falling_sel_in ? (wait_in | wait_prev) : wait_in;
    end
endmodule // hbsws_wait_sampler
`default_nettype wire

// ===== core/hbsws_top.v
`timescale 1ns/10ps
`default_nettype none
`include "hbsws_regs.vh"
module hbsws_top (
    input wire clock_in,
    input wire rst_n_in,
    input wire host_mode_select_low_in,
    input wire host_mode_select_high_in,
    input wire system_stop_in,
    input wire dma_bus_granted_in,
    input wire dma_cycle_start_in,
    input wire dma_high_byte_in,
    input wire reg_cycle_busy_in,
    input wire high_byte_enable_in,
    output reg high_byte_enable_out,
    output wire high_byte_enable_oe_n_out,
    input wire device_select_n_in,
    input wire wait_in,
    output reg wait_out,
    output wire wait_oe_n_out,
    input wire address_strobe_n_in,
    output reg address_strobe_n_out,
    output wire address_strobe_oe_n_out,
    output reg [1:0] host_mode_out,
    output reg is_master_out,
    output reg reg_cycle_start_out,
    output reg reg_high_byte_out,
    output reg slave_addr_valid_out,
    output reg [4:0] bus_state_out,
    output reg dma_cycle_done_out
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Modes 2 and 3 share the strobe-style pin meanings.
    function is_upper_pair;
        input [1:0] m;
        begin
            is_upper_pair = (m == `HBSWS_MODE_2) || (m == `HBSWS_MODE_3);
        end
    endfunction

    // True in every state that owns the address bus (T1 to T3).
    function is_bus_state;
        input [4:0] s;
        begin
            is_bus_state = (s != `HBSWS_ST_IDLE);
        end
    endfunction

    // True where the upper strobe times a byte (T2, Tw and T3).
    function is_data_state;
        input [4:0] s;
        begin
            is_data_state = (s == `HBSWS_ST_T2) || (s == `HBSWS_ST_TW) ||
                            (s == `HBSWS_ST_T3);
        end
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg mode_caught;
    reg [1:0] host_mode;
    reg [4:0] state;
    reg [4:0] next_state;
    reg cs_prev;
    reg [3:0] slave_wait_cnt;
    wire wait_high;
    wire granted;
    wire master;
    wire mode_zero;
    wire mode_one;
    wire mode_hi_pair;
    wire cs_active;
    wire cs_begin;
    wire slave_addr_gate;
    wire slave_wait_done;

    // ------------------------------------------------------------------
    // Mode capture
    // ------------------------------------------------------------------
    // The selects are static, so they are caught once after reset release.
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_caught <= 1'b0;
            host_mode <= `HBSWS_MODE_0;
        end else if (!mode_caught) begin
            mode_caught <= 1'b1;
            host_mode <= {host_mode_select_high_in,
                          host_mode_select_low_in};
        end
    end

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            host_mode_out <= `HBSWS_MODE_0;
        end else begin
            host_mode_out <= host_mode;
        end
    end

    assign mode_zero = (host_mode == `HBSWS_MODE_0);
    assign mode_one = (host_mode == `HBSWS_MODE_1);
    assign mode_hi_pair = is_upper_pair(host_mode);

    // ------------------------------------------------------------------
    // Master state
    // ------------------------------------------------------------------
    // The sequencer reacts to the grant at once, but the pin directions
    // follow the registered state, so reset leaves the strobe and high byte
    // pins inputs and wait driven, and the reported state and the directions never disagree.
    assign granted = dma_bus_granted_in & ~system_stop_in;

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            is_master_out <= 1'b0;
        end else begin
            is_master_out <= granted;
        end
    end

    assign master = is_master_out;

    // ------------------------------------------------------------------
    // Pin directions
    // ------------------------------------------------------------------
    // Wait is driven in reset, stop and slave (high in reset and stop).
    assign high_byte_enable_oe_n_out =
        ~(master & ~mode_one);
    assign address_strobe_oe_n_out = ~master;
    assign wait_oe_n_out = master;

    // ------------------------------------------------------------------
    // Master bus-state sequencer
    // ------------------------------------------------------------------
    hbsws_wait_sampler hbsws_wait_sampler_i (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .wait_in(wait_in),
        .falling_sel_in(~mode_zero),
        .wait_high_out(wait_high)
    );

    always @* begin
        next_state = state;
        case (state)
            `HBSWS_ST_IDLE: begin
                if (dma_cycle_start_in) begin
                    next_state = `HBSWS_ST_T1;
                end
            end
            `HBSWS_ST_T1: begin
                next_state = `HBSWS_ST_T2;
            end
            `HBSWS_ST_T2, `HBSWS_ST_TW: begin
                if (wait_high) begin
                    next_state = `HBSWS_ST_TW;
                end else begin
                    next_state = `HBSWS_ST_T3;
                end
            end
            `HBSWS_ST_T3: begin
                next_state = `HBSWS_ST_IDLE;
            end
            default: begin
                next_state = `HBSWS_ST_IDLE;
            end
        endcase
        // A lost grant or a stop ends the cycle at once.
        if (!granted) begin
            next_state = `HBSWS_ST_IDLE;
        end
    end

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= `HBSWS_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_state_out <= `HBSWS_ST_IDLE;
        end else begin
            bus_state_out <= next_state;
        end
    end

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dma_cycle_done_out <= 1'b0;
        end else begin
            dma_cycle_done_out <= (state == `HBSWS_ST_T3);
        end
    end

    // ------------------------------------------------------------------
    // Master strobes
    // ------------------------------------------------------------------
    // Strobe low from T1 through T3: full or word address valid.
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            address_strobe_n_out <= 1'b1;
        end else begin
            address_strobe_n_out <=
                ~is_bus_state(next_state);
        end
    end

    // Mode 0 marks the whole cycle; modes 2 and 3 only the data states.
    // Mode 1 has no high byte pin, so the output rests high.
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            high_byte_enable_out <= 1'b1;
        end else if (mode_zero) begin
            high_byte_enable_out <=
                ~(is_bus_state(next_state) & dma_high_byte_in);
        end else if (mode_hi_pair) begin
            high_byte_enable_out <=
                ~(is_data_state(next_state) & dma_high_byte_in);
        end else begin
            high_byte_enable_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Slave access
    // ------------------------------------------------------------------
    // Select is only looked at outside reset, stop and mastership; the
    // raw grant is included so that no register cycle can start in the
    // cycle in which the device takes the bus.
    assign cs_active = ~device_select_n_in & ~master &
                       ~dma_bus_granted_in & ~system_stop_in;
    assign cs_begin = cs_active & ~cs_prev;

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_prev <= 1'b0;
        end else begin
            cs_prev <= cs_active;
        end
    end

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_cycle_start_out <= 1'b0;
        end else begin
            reg_cycle_start_out <= cs_begin;
        end
    end

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_high_byte_out <= 1'b0;
        end else if (cs_begin) begin
            reg_high_byte_out <= ~high_byte_enable_in;
        end
    end

    // Modes 0 and 1 ignore the strobe, so the select alone frames the
    // address there.
    assign slave_addr_gate = mode_hi_pair ? ~address_strobe_n_in
                                          : 1'b1;

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slave_addr_valid_out <= 1'b0;
        end else begin
            slave_addr_valid_out <= cs_active & slave_addr_gate;
        end
    end

    // Wait high lengthens the host cycle until the register file has had
    // a minimum number of cycles and reports not busy.
    assign slave_wait_done = (slave_wait_cnt == `HBSWS_SLAVE_WAIT_CYCLES);

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slave_wait_cnt <= 4'h0;
        end else if (!cs_active) begin
            slave_wait_cnt <= 4'h0;
        end else if (!slave_wait_done) begin
            slave_wait_cnt <= slave_wait_cnt + 4'h1;
        end
    end

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_out <= 1'b1;
        end else if (system_stop_in) begin
            wait_out <= 1'b1;
        end else begin
            wait_out <= cs_active &
                (~slave_wait_done | reg_cycle_busy_in);
        end
    end
endmodule // hbsws_top
`default_nettype wire

// ===== testbench/hbsws_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "hbsws_regs.vh"
module hbsws_checker (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic system_stop_in,
    input wire logic dma_bus_granted_in,
    input wire logic device_select_n_in,
    input wire logic wait_in,
    input wire logic high_byte_enable_oe_n_out,
    input wire logic wait_oe_n_out,
    input wire logic address_strobe_n_out,
    input wire logic address_strobe_oe_n_out,
    input wire logic [1:0] host_mode_out,
    input wire logic is_master_out,
    input wire logic reg_cycle_start_out,
    input wire logic [4:0] bus_state_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // A lost grant or a stop may end a cycle early, so steps need both.
    wire go = dma_bus_granted_in && !system_stop_in;
    wire t2w = bus_state_out == `HBSWS_ST_T2 || bus_state_out == `HBSWS_ST_TW;
    wire m0 = host_mode_out == `HBSWS_MODE_0;
    hbe_dir_a: assert property (
        high_byte_enable_oe_n_out == !(is_master_out && host_mode_out != 2'h1))
        else $error("high byte pin direction");
    wait_dir_a: assert property (wait_oe_n_out == $past(go))
        else $error("wait pin direction");
    strobe_dir_a: assert property (
        address_strobe_oe_n_out == !is_master_out) else $error("strobe dir");
    grant_loss_a: assert property (!dma_bus_granted_in |=> !is_master_out)
        else $error("master without grant");
    select_start_a: assert property (
        $fell(device_select_n_in) && !is_master_out && !system_stop_in &&
        !dma_bus_granted_in |=> reg_cycle_start_out) else $error("no start");
    select_ignore_a: assert property (
        is_master_out || system_stop_in |=> !reg_cycle_start_out)
        else $error("select not ignored");
    rise_wait_a: assert property (t2w && m0 && go |=>
        bus_state_out == ($past(wait_in) ? `HBSWS_ST_TW : `HBSWS_ST_T3))
        else $error("mode 0 wait step");
    fall_wait_a: assert property (
        t2w && !m0 && go && wait_in |=> bus_state_out == `HBSWS_ST_TW)
        else $error("wait state missing");
    strobe_low_a: assert property (
        (bus_state_out != `HBSWS_ST_IDLE) == !address_strobe_n_out)
        else $error("strobe timing");
    strobe_owner_a: assert property (
        !address_strobe_n_out |-> !address_strobe_oe_n_out)
        else $error("strobe low while not driven");
endmodule // hbsws_checker
bind hbsws_top hbsws_checker hbsws_checker_i (.*);
`default_nettype wire

// ===== testbench/hbsws_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hbsws_host_model (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic address_strobe_n_in,
    input wire logic [3:0] wait_cycles_in,
    output logic wait_out
);
    logic [3:0] count;
    logic toggle;
    // Outside a strobed cycle nobody holds the line, so it never sits still.
    assign wait_out = address_strobe_n_in ? toggle :
        (count != 4'h0 && count <= wait_cycles_in);
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= 4'h0;
            toggle <= 1'b0;
        end else begin
            toggle <= !toggle;
            count <= address_strobe_n_in ? 4'h0 : count + 4'h1;
        end
    end
endmodule // hbsws_host_model
`default_nettype wire

// ===== testbench/hbsws_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "hbsws_regs.vh"
module hbsws_top_bench;
    logic clk = 0, rst_n = 0, s_lo = 0, s_hi = 0, stop = 0, grant = 0;
    logic start = 0, busy = 0, hbe_h = 1, sel_n = 1, as_h = 1, hbyte = 1;
    logic [3:0] n_wait = 0;
    wire hbe_o, hbe_oe_n, wait_o, wait_oe_n, as_o, as_oe_n, rstart, rhb;
    wire sav, done, h_wait;
    wire [1:0] mode;
    wire [4:0] st;
    wire as_l = as_oe_n ? as_h : as_o;
    int n_fail = 0, check_count = 0;
    hbsws_top hbsws_top_i (.clock_in(clk), .rst_n_in(rst_n),
        .host_mode_select_low_in(s_lo), .host_mode_select_high_in(s_hi),
        .system_stop_in(stop), .dma_bus_granted_in(grant),
        .dma_cycle_start_in(start), .dma_high_byte_in(hbyte),
        .reg_cycle_busy_in(busy),
        .high_byte_enable_in(hbe_oe_n ? hbe_h : hbe_o),
        .high_byte_enable_out(hbe_o), .high_byte_enable_oe_n_out(hbe_oe_n),
        .device_select_n_in(sel_n), .wait_in(wait_oe_n ? h_wait : wait_o),
        .wait_out(wait_o), .wait_oe_n_out(wait_oe_n),
        .address_strobe_n_in(as_l), .address_strobe_n_out(as_o),
        .address_strobe_oe_n_out(as_oe_n), .host_mode_out(mode),
        .is_master_out(), .reg_cycle_start_out(rstart),
        .reg_high_byte_out(rhb), .slave_addr_valid_out(sav),
        .bus_state_out(st), .dma_cycle_done_out(done));
    hbsws_host_model hbsws_host_model_i (.clock_in(clk), .rst_n_in(rst_n),
        .address_strobe_n_in(as_l), .wait_cycles_in(n_wait), .wait_out(h_wait));
    initial forever #4 clk = ~clk;
    initial begin
        #300000 n_fail++;
        summarize();
    end
    task automatic chk(string w, logic [4:0] e, logic [4:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic do_reset(logic [1:0] m);
        @(posedge clk) rst_n <= 0;
        {s_hi, s_lo} <= m;
        repeat (4) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(posedge clk);
        #1 chk("mode", 5'(m), 5'(mode));
        @(posedge clk) stop <= 1;
        sel_n <= 0;
        repeat (3) @(posedge clk);
        #1 chk("stop", 5'h01, {2'h0, wait_oe_n, rstart, wait_o});
        @(posedge clk) stop <= 0;
        sel_n <= 1;
    endtask
    task automatic slave_cycle();
        int k;
        @(posedge clk) busy <= 1;
        sel_n <= 0;
        hbe_h <= mode == 2'h1;
        @(posedge clk) #1 chk("start", 5'h1, 5'(rstart));
        chk("high byte", 5'(mode != 2'h1), 5'(rhb));
        repeat (3) @(posedge clk);
        #1 chk("slave wait", 5'h1, {3'h0, wait_oe_n, wait_o});
        chk("addr ignored", 5'(!mode[1]), 5'(sav));
        @(posedge clk) busy <= 0;
        as_h <= 0;
        #1;
        for (k = 0; k < 9 && wait_o !== 1'b0; k++) #8;
        chk("wait end", 5'h0, 5'(wait_o));
        chk("addr valid", 5'h1, 5'(sav));
        @(posedge clk) sel_n <= 1;
        as_h <= 1;
    endtask
    task automatic master_cycle(logic [3:0] n);
        int k, tw;
        tw = 0;
        @(posedge clk) n_wait <= n;
        hbyte <= n[1];
        grant <= 1;
        start <= 1;
        @(posedge clk) start <= 0;
        for (k = 0; k < 30 && done !== 1'b1; k++) begin
            @(posedge clk) #1;
            tw += st === `HBSWS_ST_TW;
            if (st === `HBSWS_ST_T2) begin
                chk("hbe dir", 5'(mode == 2'h1), 5'(hbe_oe_n));
                chk("hbe level", 5'(mode == 2'h1 || !hbyte), 5'(hbe_o));
                chk("strobe", 5'h0, {3'h0, as_oe_n, as_o});
            end
        end
        chk("done", 5'h1, 5'(done));
        chk("waits", 5'h1, 5'(tw >= n && tw <= n + (mode != 2'h0)));
        @(posedge clk) grant <= 0;
    endtask
    initial begin
        for (int m = 0; m < 4; m++) begin
            do_reset(2'(m));
            slave_cycle();
            master_cycle(4'h0);
            master_cycle(4'h2);
        end
        summarize();
    end
endmodule // hbsws_top_bench
`default_nettype wire
